// ==== logic/eip_pkg.sv ====
// package of constants and types for the external interrupt pin block
package eip_pkg;
  // ***********************************************************
  // widths and counts
  // ***********************************************************
  localparam int EIP_NUM_EXT = 4;
  localparam int EIP_NUM_SRC = 5;
  localparam int EIP_ID_W = 4;
  localparam int EIP_ADDR_W = 4;
  // ***********************************************************
  // register byte offsets
  // ***********************************************************
  localparam logic [EIP_ADDR_W-1:0] EIP_OFS_POLARITY = 4'h0;
  localparam logic [EIP_ADDR_W-1:0] EIP_OFS_PENDING = 4'h4;
  localparam logic [EIP_ADDR_W-1:0] EIP_OFS_SERVICE = 4'h8;
  localparam logic [EIP_ADDR_W-1:0] EIP_OFS_LAST_ID = 4'hc;
  // ***********************************************************
  // reset values and service slot ids
  // ***********************************************************
  localparam logic [EIP_NUM_EXT-1:0] EIP_POL_RESET = 4'h0;
  localparam logic [EIP_ID_W-1:0] EIP_ID_NMI = 4'h1;
  localparam logic [EIP_ID_W-1:0] EIP_ID_EXT_BASE = 4'h4;
  localparam logic [1:0] EIP_RESP_OKAY = 2'h0;
  localparam logic [1:0] EIP_RESP_SLVERR = 2'h2;
  // ***********************************************************
  // carrier of the acknowledge strobe and its id
  // ***********************************************************
  typedef struct packed {
    logic strobe;
    logic [EIP_ID_W-1:0] id;
  } eip_ack_s;
endpackage : eip_pkg

// ==== logic/eip_top.sv ====
// external interrupt pin logic with an axi4-lite register slave
//
// The register addresses and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module eip_top
  import eip_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_nmi,
  input wire logic [eip_pkg::EIP_NUM_EXT-1:0] i_ext_irq_in,
  output eip_pkg::eip_ack_s o_irq_service,
  output logic o_nmi_pending,
  output logic [eip_pkg::EIP_NUM_EXT-1:0] o_ext_pending,
  input wire logic [eip_pkg::EIP_ADDR_W-1:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [eip_pkg::EIP_ADDR_W-1:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready
);
  import eip_pkg::*;

  // ***********************************************************
  // input synchronisers and edge detection
  // ***********************************************************
  logic [EIP_NUM_SRC-1:0] raw_in;
  logic [EIP_NUM_SRC-1:0] sync1;
  logic [EIP_NUM_SRC-1:0] sync2;
  logic [EIP_NUM_SRC-1:0] sync_prev;
  logic [EIP_NUM_SRC-1:0] edge_hit;
  logic [EIP_NUM_SRC-1:0] pending;
  logic [EIP_NUM_SRC-1:0] svc_clear;
  logic [EIP_NUM_EXT-1:0] ext_irq_edge_polarity;
  logic svc_fire;
  logic [EIP_ID_W-1:0] svc_id;

  assign raw_in = {i_ext_irq_in, i_nmi};

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sync1 <= '0;
      sync2 <= '0;
      sync_prev <= '0;
    end else begin
      sync1 <= raw_in;
      sync2 <= sync1;
      sync_prev <= sync2;
    end
  end

  assign edge_hit[0] = sync2[0] && !sync_prev[0];

  genvar gi;
  generate
    for (gi = 0; gi < EIP_NUM_EXT; gi++) begin : g_ext
      assign edge_hit[gi+1] = ext_irq_edge_polarity[gi] ? (sync_prev[gi+1] && !sync2[gi+1])
                                                        : (sync2[gi+1] && !sync_prev[gi+1]);
      // external slot ids 4 to 7
      assign svc_clear[gi+1] = svc_fire && (svc_id == EIP_ID_EXT_BASE + EIP_ID_W'(gi));
    end
  endgenerate

  assign svc_clear[0] = svc_fire && (svc_id == EIP_ID_NMI);

  // pending latch, a new edge wins over the clear
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pending <= '0;
    end else begin
      pending <= (pending & ~svc_clear) | edge_hit;
    end
  end

  assign o_nmi_pending = pending[0];
  assign o_ext_pending = pending[EIP_NUM_SRC-1:1];

  // ***********************************************************
  // axi4-lite write channel
  // ***********************************************************
  // address and data are held until both have arrived, in either order
  logic aw_held;
  logic w_held;
  logic [EIP_ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_go;

  assign o_awready = !aw_held && !o_bvalid;
  assign o_wready = !w_held && !o_bvalid;
  assign wr_go = aw_held && w_held && !o_bvalid;

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
    end else begin
      if (i_awvalid && o_awready) begin
        aw_held <= 1'b1;
        aw_addr <= i_awaddr;
      end else if (wr_go) begin
        aw_held <= 1'b0;
      end
      if (i_wvalid && o_wready) begin
        w_held <= 1'b1;
        w_data <= i_wdata;
        w_strb <= i_wstrb;
      end else if (wr_go) begin
        w_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_bvalid <= 1'b0;
      o_bresp <= EIP_RESP_OKAY;
    end else if (wr_go) begin
      o_bvalid <= 1'b1;
      o_bresp <= (aw_addr == EIP_OFS_POLARITY || aw_addr == EIP_OFS_SERVICE) ? EIP_RESP_OKAY
                                                                            : EIP_RESP_SLVERR;
    end else if (i_bready) begin
      o_bvalid <= 1'b0;
    end
  end

  // polarity register, steers edge selection
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ext_irq_edge_polarity <= EIP_POL_RESET;
    end else if (wr_go && aw_addr == EIP_OFS_POLARITY && w_strb[0]) begin
      ext_irq_edge_polarity <= w_data[EIP_NUM_EXT-1:0];
    end
  end

  // ***********************************************************
  // service and acknowledge
  // ***********************************************************
  // a write to the service register is the core servicing slot svc_id
  assign svc_fire = wr_go && aw_addr == EIP_OFS_SERVICE && w_strb[0];
  assign svc_id = w_data[EIP_ID_W-1:0];

  // one process for the whole carrier, so strobe and id never have two drivers
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_irq_service <= '0;
    end else begin
      o_irq_service.strobe <= svc_fire;
      // id stays valid with and after the strobe
      if (svc_fire) begin
        o_irq_service.id <= svc_id;
      end
    end
  end

  // ***********************************************************
  // axi4-lite read channel
  // ***********************************************************
  assign o_arready = !o_rvalid;

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rvalid <= 1'b0;
      o_rdata <= '0;
      o_rresp <= EIP_RESP_OKAY;
    end else if (i_arvalid && o_arready) begin
      o_rvalid <= 1'b1;
      o_rresp <= EIP_RESP_OKAY;
      case (i_araddr)
        EIP_OFS_POLARITY: o_rdata <= {28'h0, ext_irq_edge_polarity};
        EIP_OFS_PENDING: o_rdata <= {27'h0, pending};
        EIP_OFS_SERVICE: o_rdata <= 32'h0;
        EIP_OFS_LAST_ID: o_rdata <= {28'h0, o_irq_service.id};
        default: begin
          o_rdata <= 32'h0;
          o_rresp <= EIP_RESP_SLVERR;
        end
      endcase
    end else if (i_rready) begin
      o_rvalid <= 1'b0;
    end
  end

  // ***********************************************************
  // assertions
  // ***********************************************************
  AST_NMI_EDGE: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (sync2[0] && !sync_prev[0]) |=> pending[0])
    else $error("nmi rising edge not latched");

  AST_NMI_LEVEL: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (!pending[0] && sync2[0] && sync_prev[0]) |=> !pending[0])
    else $error("nmi level raised a new event");

  AST_EXT_POL: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (!ext_irq_edge_polarity[0] && $fell(sync2[1]) && !pending[1]) |=> !pending[1])
    else $error("external input fired on the wrong edge");

  AST_ACK_PULSE: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    svc_fire |=> o_irq_service.strobe ##1 !o_irq_service.strobe || $past(svc_fire))
    else $error("acknowledge did not follow service");

  AST_ACK_ID: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    svc_fire |=> o_irq_service.id == $past(svc_id))
    else $error("acknowledge id does not match serviced slot");

  AST_SLOT_CLEAR: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (svc_fire && svc_id == EIP_ID_EXT_BASE && !edge_hit[1]) |=> !pending[1])
    else $error("slot 4 service did not clear first external input");

  AST_HOLD: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (pending[2] && !svc_clear[2]) |=> pending[2])
    else $error("pending edge lost before service");
endmodule : eip_top

// ==== bench/eip_src.sv ====
// model of the interrupt sources that drive the block pins
`timescale 1ns/1ps
module eip_src (
  input wire logic i_sys_clk,
  input wire logic [4:0] i_flip,
  output logic o_nmi,
  output logic [3:0] o_ext
);
  // levels change only on command and then hold, so each lasts as long as the bench waits
  logic [4:0] lvl = 5'h00;
  always @(posedge i_sys_clk) begin
    lvl <= lvl ^ i_flip;
  end
  assign {o_ext, o_nmi} = lvl;
endmodule : eip_src

// ==== bench/testbench.sv ====
// self-checking bench for the external interrupt pin block
`timescale 1ns/1ps
module testbench;
  import eip_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] awaddr = 4'h0;
  logic [3:0] araddr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [4:0] flip = 5'h00;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid, nmi, nmi_pend, s;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, rd;
  logic [3:0] ext, ext_pend, sid, pol, f, lv, exp;
  eip_ack_s svc;
  int errors = 0;
  int total_checks = 0;

  always #5 clk = ~clk;

  eip_top DUT (.i_sys_clk(clk), .i_rstn(rstn), .i_nmi(nmi), .i_ext_irq_in(ext), .o_irq_service(svc),
    .o_nmi_pending(nmi_pend), .o_ext_pending(ext_pend), .i_awaddr(awaddr), .i_awvalid(awvalid),
    .o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready),
    .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
    .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready));
  eip_src src (.i_sys_clk(clk), .i_flip(flip), .o_nmi(nmi), .o_ext(ext));

  // ********
  // tasks
  // ********
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] want);
    total_checks++;
    if (seen !== want) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, want, seen);
    end
  endtask : chk

  // an extra edge first, so no strobe is lowered and raised in one time step
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bit done;
    done = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        resp = bresp;
        s = svc.strobe;
        sid = svc.id;
        bready <= 1'b0;
        done = 1;
      end
    end
  endtask : wr

  task automatic rdr(input logic [3:0] a);
    bit done;
    done = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
        done = 1;
      end
    end
  endtask : rdr

  // pins toggle once and hold, then 8 cycles pass, well past the sync and pending latency
  task automatic pulse(input logic [4:0] m);
    @(posedge clk);
    flip <= m;
    @(posedge clk);
    flip <= 5'h00;
    repeat (8) @(posedge clk);
  endtask : pulse

  task automatic complete_run;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : complete_run

  // ********
  // tests
  // ********
  initial begin
    lv = 4'h0;
    void'($urandom(84231));
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    rdr(EIP_OFS_PENDING);
    chk("pending", rd, 0);
    rdr(EIP_OFS_POLARITY);
    chk("polarity", rd, 0);
    $display("test reset done");
    pulse(5'h01);
    chk("nmi_pend", 32'(nmi_pend), 1);
    wr(EIP_OFS_SERVICE, 32'(EIP_ID_NMI));
    chk("strobe", 32'(s), 1);
    chk("nmi_id", 32'(sid), 1);
    chk("nmi_clr", 32'(nmi_pend), 0);
    repeat (8) @(posedge clk);
    chk("nmi_level", 32'(nmi_pend), 0);
    pulse(5'h01);
    chk("nmi_fall", 32'(nmi_pend), 0);
    $display("test nmi done");
    repeat (6) begin
      pol = 4'($urandom);
      f = 4'($urandom);
      wr(EIP_OFS_POLARITY, {28'h0, pol});
      rdr(EIP_OFS_POLARITY);
      chk("polarity", rd, {28'h0, pol});
      for (int i = 0; i < 4; i++) exp[i] = f[i] && (pol[i] ? lv[i] : !lv[i]);
      pulse({f, 1'b0});
      lv = lv ^ f;
      rdr(EIP_OFS_PENDING);
      chk("pending", rd, {27'h0, exp, 1'b0});
      for (int i = 0; i < 4; i++) wr(EIP_OFS_SERVICE, 32'(4 + i));
      chk("ext_clr", 32'(ext_pend), 0);
    end
    $display("test edges done");
    for (int i = 0; i < 16; i++) begin
      wr(EIP_OFS_SERVICE, 32'(i));
      chk("strobe", 32'(s), 1);
      chk("id", 32'(sid), 32'(i));
    end
    @(posedge clk);
    chk("strobe_off", 32'(svc.strobe), 0);
    rdr(EIP_OFS_LAST_ID);
    chk("last_id", rd, 32'hf);
    $display("test ids done");
    wr(EIP_OFS_PENDING, 32'h0);
    chk("ro_resp", 32'(resp), 32'(EIP_RESP_SLVERR));
    wr(4'h6, 32'h0);
    chk("wr_unmapped", 32'(resp), 32'(EIP_RESP_SLVERR));
    rdr(4'h2);
    chk("rd_unmapped", 32'(resp), 32'(EIP_RESP_SLVERR));
    wstrb <= 4'h0;
    wr(EIP_OFS_POLARITY, 32'hf);
    wstrb <= 4'hf;
    chk("strb_resp", 32'(resp), 32'(EIP_RESP_OKAY));
    rdr(EIP_OFS_POLARITY);
    chk("strb_off", rd, {28'h0, pol});
    $display("test errors done");
    complete_run();
  end

  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    complete_run();
  end
endmodule : testbench
